// ===== rtl/mci_interlock.sv
// contactor interlock, trip latching and setpoint gating logic
`timescale 1ns/1ps
`include "mci_defs.svh"
module mci_interlock
	import mci_pkg::*;
#(
	parameter int unsigned debounce_cycles = `MCI_DEBOUNCE_CYC
)
(
	// clock and reset
	input  wire logic           clock,
	input  wire logic           rst,
	// raw switch pins, 120 VAC inputs after level conversion
	input  wire mci_sw_type     sw_pin,
	// configuration
	input  wire mci_duty_type   duty,
	// internal protection events, one-cycle pulses
	input  wire mci_trip_type   trip_event,
	// serial link commands
	input  wire mci_serial_type serial_cmd,
	// keypad
	input  wire logic           keypad_reset,
	input  wire logic           keypad_store,
	// control power
	input  wire logic           power_good,
	// cool-down result from the thermal model
	input  wire logic           cooled,
	// statistics requests from the motor model
	input  wire logic           stat_run_tick,
	input  wire logic           stat_start,
	input  wire logic           stat_trip,
	// contactor outputs
	output logic                contactor_a,
	output logic                contactor_b,
	// status
	output logic                test_pos_closed,
	output logic                isolator_open,
	output mci_trip_type        trip_latched,
	output logic                access_enabled,
	output logic                setpoint_write,
	output logic                tc_clear,
	output logic                stat_run_en,
	output logic                stat_start_en,
	output logic                stat_trip_en
);
	typedef struct packed {
		mci_sw_type   last;
		mci_trip_type trips;
		logic         power_prev;
		logic         access_en;
		logic         out_a;
		logic         out_b;
		logic         test_pos;
		logic         iso_open;
		logic         sp_write;
		logic         tc_clr;
		logic         st_run;
		logic         st_start;
		logic         st_trip;
	} mci_state_type;

	mci_state_type state;
	mci_state_type next_state;
	mci_sw_type    sw;

	// one synchroniser and filter per switch
	genvar gi;
	generate
		for (gi = 0; gi < `MCI_NUM_SW; gi++)
		begin : g_db
			mci_debounce #(
				.settle (debounce_cycles)
			) u_db (
				.clock (clock),
				.rst   (rst),
				.pin   (sw_pin[gi]),
				.level (sw[gi])
			);
		end
	endgenerate

	// decision logic
	always_comb
	begin
		logic         any_trip;
		logic         drop_both;
		logic         drop_a;
		logic         drop_b;
		logic         close_ok;
		logic         go_a;
		logic         go_b;
		logic         b_allowed;
		logic         lockout_edge;
		logic         power_back;
		mci_trip_type keep;
		any_trip     = 1'b0;
		drop_both    = 1'b0;
		drop_a       = 1'b0;
		drop_b       = 1'b0;
		close_ok     = 1'b0;
		go_a         = 1'b0;
		go_b         = 1'b0;
		b_allowed    = 1'b0;
		lockout_edge = 1'b0;
		power_back   = 1'b0;
		keep         = '0;
		next_state   = state;
		next_state.last = sw;
		next_state.power_prev = power_good;
		next_state.test_pos = sw.test_pos;
		next_state.iso_open = !sw.iso_no || sw.iso_nc;

		// trip clearing
		lockout_edge = sw.lockout_reset && !state.last.lockout_reset;
		power_back = power_good && !state.power_prev;
		if (keypad_reset)
		begin
			// keypad clears only the recoverable trips
			next_state.trips.single_phase = 1'b0;
			next_state.trips.undercurrent = 1'b0;
			next_state.trips.accel_time   = 1'b0;
			next_state.trips.link_fail    = 1'b0;
			if (cooled)
				next_state.trips.thermistor = 1'b0;
			if (!state.trips.thermal_lockout)
				next_state.trips.overcurrent = 1'b0;
		end
		if (lockout_edge || serial_cmd.trip_reset)
		begin
			// lockout trips cleared by the input or the serial link
			next_state.trips.ground_fault  = 1'b0;
			next_state.trips.stalled_rotor = 1'b0;
			next_state.trips.overload      = 1'b0;
			next_state.trips.overcurrent   = 1'b0;
			if (cooled)
				next_state.trips.thermal_lockout = 1'b0;
		end
		if (power_back)
		begin
			// on power return only thermal lockout and ground fault stay
			keep = '0;
			keep.ground_fault    = state.trips.ground_fault;
			keep.thermal_lockout = state.trips.thermal_lockout;
			next_state.trips = keep;
		end
		// new events win over any clear in the same cycle
		next_state.trips = next_state.trips | trip_event;

		// thermal capacity zeroed by the lockout input on overcurrent
		next_state.tc_clr = lockout_edge && state.trips.overcurrent;

		// contactor drop conditions
		any_trip = (|state.trips) || (|trip_event) || !power_good;
		drop_both = any_trip
			|| (state.last.test_pos && !sw.test_pos)
			|| (state.last.interlock && !sw.interlock)
			|| (state.out_a && state.last.stat_a_closed && !sw.stat_a_closed)
			|| (state.out_b && state.last.stat_b_closed && !sw.stat_b_closed)
			|| next_state.iso_open
			|| ((state.out_a || state.out_b)
				&& ((state.last.iso_no && !sw.iso_no) || (!state.last.iso_nc && sw.iso_nc)));
		drop_a = !sw.stop_ok && state.out_a;
		drop_b = !sw.stop_ok && state.out_b;

		// start sources, local or serial
		close_ok = sw.interlock && sw.stop_ok && !drop_both;
		b_allowed = (duty == mci_reversing) || (duty == mci_two_speed);
		if (sw.local_remote)
		begin
			go_a = serial_cmd.start_a;
			go_b = serial_cmd.start_b;
		end
		else
		begin
			go_a = sw.start_a && !state.last.start_a;
			go_b = sw.start_b && !state.last.start_b;
		end

		// latch outputs; A for line/forward/speed1/star, B for reverse/speed2 only (B never closes in star-delta)
		if (drop_both || drop_a)
			next_state.out_a = 1'b0;
		else if (go_a && close_ok && !state.out_b)
			next_state.out_a = 1'b1;
		if (drop_both || drop_b)
			next_state.out_b = 1'b0;
		else if (go_b && b_allowed && close_ok && !state.out_a)
			next_state.out_b = 1'b1;

		// setpoint access
		if (serial_cmd.access_disable)
			next_state.access_en = 1'b0;
		else if (serial_cmd.access_enable)
			next_state.access_en = 1'b1;
		next_state.sp_write = serial_cmd.store_setpoint
			|| (keypad_store && sw.access_short && state.access_en);

		// statistics blocked in test position
		next_state.st_run   = stat_run_tick && !sw.test_pos;
		next_state.st_start = stat_start && !sw.test_pos;
		next_state.st_trip  = stat_trip && !sw.test_pos;
	end

	// state register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= '0;
			state.access_en <= 1'b1;
			state.last.stop_ok <= 1'b0;
		end
		else
			state <= next_state;
	end

	// outputs straight from the state register
	assign contactor_a     = state.out_a;
	assign contactor_b     = state.out_b;
	assign test_pos_closed = state.test_pos;
	assign isolator_open   = state.iso_open;
	assign trip_latched    = state.trips;
	assign access_enabled  = state.access_en;
	assign setpoint_write  = state.sp_write;
	assign tc_clear        = state.tc_clr;
	assign stat_run_en     = state.st_run;
	assign stat_start_en   = state.st_start;
	assign stat_trip_en    = state.st_trip;
endmodule : mci_interlock

// ===== rtl/mci_defs.svh
// constants for the motor contactor interlock logic
`ifndef MCI_DEFS_SVH
`define MCI_DEFS_SVH
`define MCI_CLK_MHZ       250
`define MCI_DEBOUNCE_MS   10
`define MCI_DEBOUNCE_CYC  (`MCI_DEBOUNCE_MS * 1000 * `MCI_CLK_MHZ)
`define MCI_CNT_W         22
`define MCI_TC_ZERO       8'h00
`define MCI_TC_W          8
`define MCI_NUM_SW        12
`endif

// ===== rtl/mci_pkg.sv
// types for the motor contactor interlock logic
package mci_pkg;
	// debounced switch inputs, one bit each
	typedef struct packed {
		logic test_pos;
		logic lockout_reset;
		logic access_short;
		logic iso_no;
		logic iso_nc;
		logic interlock;
		logic start_a;
		logic start_b;
		logic stop_ok;
		logic stat_a_closed;
		logic stat_b_closed;
		logic local_remote;
	} mci_sw_type;

	// trip causes
	typedef struct packed {
		logic single_phase;
		logic thermistor;
		logic overcurrent;
		logic undercurrent;
		logic accel_time;
		logic link_fail;
		logic ground_fault;
		logic stalled_rotor;
		logic overload;
		logic thermal_lockout;
	} mci_trip_type;

	// commands from the serial link decoder, one-cycle pulses
	typedef struct packed {
		logic start_a;
		logic start_b;
		logic trip_reset;
		logic access_disable;
		logic access_enable;
		logic store_setpoint;
	} mci_serial_type;

	// contactor duty selection
	typedef enum logic [1:0] {
		mci_direct,
		mci_reversing,
		mci_two_speed,
		mci_star_delta
	} mci_duty_type;
endpackage : mci_pkg

// ===== rtl/mci_debounce.sv
// two-flop synchroniser and debounce filter for one switch input
`timescale 1ns/1ps
`include "mci_defs.svh"
module mci_debounce
	import mci_pkg::*;
#(
	parameter int unsigned settle = 1000
)
(
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// raw pin and filtered level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic                    sync1;
		logic                    sync2;
		logic                    stable;
		logic [`MCI_CNT_W-1:0]   count;
	} mci_db_state_type;

	mci_db_state_type state;
	mci_db_state_type next_state;

	// follow the synchronised pin once it has held for the settle time
	always_comb
	begin
		next_state = state;
		next_state.sync1 = pin;
		next_state.sync2 = state.sync1;
		if (state.sync2 == state.stable)
			next_state.count = '0;
		else if (state.count >= `MCI_CNT_W'(settle - 1))
		begin
			next_state.stable = state.sync2;
			next_state.count = '0;
		end
		else
			next_state.count = state.count + `MCI_CNT_W'(1);
	end

	// state register
	always_ff @(posedge clock)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign level = state.stable;
endmodule : mci_debounce

// ===== testbench/mci_checker.sv
// port assertions for the contactor interlock logic
`timescale 1ns/1ps
module mci_checker
	import mci_pkg::*;
(
	// clock and reset
	input wire logic           clock,
	input wire logic           rst,
	// watched inputs
	input wire mci_duty_type   duty,
	input wire mci_trip_type   trip_event,
	input wire mci_serial_type serial_cmd,
	input wire logic           power_good,
	// watched outputs
	input wire logic           contactor_a,
	input wire logic           contactor_b,
	input wire logic           test_pos_closed,
	input wire logic           isolator_open,
	input wire mci_trip_type   trip_latched,
	input wire logic           access_enabled,
	input wire logic           setpoint_write,
	input wire logic           tc_clear,
	input wire logic           stat_run_en
);
	default clocking ck @(posedge clock); endclocking
	default disable iff (rst);
	// output relations
	property p_trip; |trip_event |=> !contactor_a && !contactor_b; endproperty
	property p_latch; |trip_latched |-> !contactor_a && !contactor_b; endproperty
	property p_iso; isolator_open |-> !contactor_a && !contactor_b; endproperty
	property p_test; test_pos_closed && $past(test_pos_closed) |-> !stat_run_en; endproperty
	property p_store; serial_cmd.store_setpoint |-> ##[1:2] setpoint_write; endproperty
	property p_dis; serial_cmd.access_disable && !serial_cmd.access_enable |-> ##[1:2] !access_enabled; endproperty
	property p_startb; $rose(contactor_b) |-> $past(duty) inside {mci_reversing, mci_two_speed}; endproperty
	property p_tc; tc_clear |-> $past(trip_latched.overcurrent); endproperty
	property p_rise; $rose(contactor_a) |-> $past(power_good) && $past(trip_latched) == '0; endproperty
	a_trip: assert property (p_trip) else $error("contactor held after trip");
	a_latch: assert property (p_latch) else $error("contactor on with trip latched");
	a_iso: assert property (p_iso) else $error("contactor on with isolator open");
	a_test: assert property (p_test) else $error("statistics in test position");
	a_store: assert property (p_store) else $error("serial store lost");
	a_dis: assert property (p_dis) else $error("access not disabled");
	a_startb: assert property (p_startb) else $error("output b in wrong duty");
	a_tc: assert property (p_tc) else $error("capacity clear without overcurrent");
	a_rise: assert property (p_rise) else $error("start while tripped or unpowered");
	// main scenarios
	c_start: cover property ($rose(contactor_a));
	c_tc: cover property (tc_clear);
	c_write: cover property (setpoint_write);
endmodule : mci_checker
bind mci_interlock mci_checker u_chk (.clock(clock), .rst(rst), .duty(duty), .trip_event(trip_event),
	.serial_cmd(serial_cmd), .power_good(power_good), .contactor_a(contactor_a), .contactor_b(contactor_b),
	.test_pos_closed(test_pos_closed), .isolator_open(isolator_open), .trip_latched(trip_latched),
	.access_enabled(access_enabled), .setpoint_write(setpoint_write), .tc_clear(tc_clear),
	.stat_run_en(stat_run_en));

// ===== testbench/mci_field.sv
// field switches with contactor aux contacts
`timescale 1ns/1ps
module mci_field
	import mci_pkg::*;
(
	// clock
	input  wire logic       clock,
	// switch settings and coil drives
	input  wire mci_sw_type set,
	input  wire logic       coil_a,
	input  wire logic       coil_b,
	// emergency stop in series with both coils, 1 = pressed
	input  wire logic       estop,
	// pins to the block
	output mci_sw_type      pin
);
	logic [1:0] aux = 2'h0;
	// aux contacts follow the coils a cycle late
	always @(posedge clock) aux <= {coil_a, coil_b} & ~{2{estop}};
	// merge aux state into the switch pins
	always_comb
	begin
		pin = set;
		pin.stat_a_closed = aux[1];
		pin.stat_b_closed = aux[0];
	end
endmodule : mci_field

// ===== testbench/testbench.sv
// self-checking bench for the contactor interlock logic
`timescale 1ns/1ps
module testbench
	import mci_pkg::*;
;
	logic           clock = 0, rst = 1, kr = 0, ks = 0, pg = 0, tick = 0;
	logic           ca, cb, tpc, acc, spw, tcc, sre, h_sp, h_run, h_tc, iso;
	logic           estop = 0;
	mci_sw_type     sw, pin;
	mci_trip_type   trip = '0, tl;
	mci_serial_type cmd = '0;
	mci_duty_type   duty = mci_direct;
	int             errors = 0, n_checks = 0, cyc = 0;
	// design and field model
	mci_interlock #(.debounce_cycles(4)) dut (.clock(clock), .rst(rst), .sw_pin(pin), .duty(duty),
		.trip_event(trip), .serial_cmd(cmd), .keypad_reset(kr), .keypad_store(ks), .power_good(pg),
		.cooled(1'b1), .stat_run_tick(tick), .stat_start(1'b0), .stat_trip(1'b0), .contactor_a(ca),
		.contactor_b(cb), .test_pos_closed(tpc), .isolator_open(iso), .trip_latched(tl), .access_enabled(acc),
		.setpoint_write(spw), .tc_clear(tcc), .stat_run_en(sre), .stat_start_en(), .stat_trip_en());
	mci_field u_field (.clock(clock), .set(sw), .coil_a(ca), .coil_b(cb), .estop(estop), .pin(pin));
	// clock and cycle ceiling
	initial forever #2 clock = ~clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			results;
		end
	end
	task automatic chk(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %0t got %b want %b", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : w
	task automatic pulse(input logic [5:0] c, input logic [9:0] t, input logic r, s, k);
		@(posedge clock);
		cmd <= mci_serial_type'(c);
		trip <= mci_trip_type'(t);
		{kr, ks, tick} <= {r, s, k};
		@(posedge clock);
		cmd <= '0;
		trip <= '0;
		{kr, ks, tick} <= 3'h0;
		#1;
	endtask : pulse
	task automatic watch(input int n);
		{h_sp, h_run, h_tc} = 3'h0;
		repeat (n)
		begin
			if (spw === 1'b1) h_sp = 1;
			if (sre === 1'b1) h_run = 1;
			if (tcc === 1'b1) h_tc = 1;
			@(posedge clock);
			#1;
		end
	endtask : watch
	task automatic t_trip;
		pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 1);
		pulse(0, 10'h002, 0, 0, 0); w(1); chk(ca, 0);
		pulse(6'h20, 10'h040, 0, 0, 0); w(1); chk(ca, 0);
		pulse(0, 0, 1, 0, 0); w(1); chk(tl.undercurrent, 0);
		chk(tl.overload, 1);
		pulse(0, 10'h080, 0, 0, 0);
		@(posedge clock) sw.lockout_reset <= 1'b1;
		watch(14); chk(h_tc, 1);
		chk(tl == '0, 1);
		@(posedge clock) sw.lockout_reset <= 1'b0;
		w(12);
	endtask : t_trip
	task automatic t_intlk;
		pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 1);
		@(posedge clock) sw.interlock <= 1'b0;
		w(12); chk(ca, 0);
		pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 0);
		@(posedge clock) sw.interlock <= 1'b1;
		w(12);
		pulse(6'h10, 0, 0, 0, 0); w(1); chk(cb, 0);
		@(posedge clock) duty <= mci_two_speed;
		pulse(6'h10, 0, 0, 0, 0); w(1); chk(cb, 1);
		@(posedge clock) sw.iso_no <= 1'b0;
		w(12); chk(cb, 0);
		chk(iso, 1);
		@(posedge clock) sw.iso_no <= 1'b1;
		w(12); chk(iso, 0);
	endtask : t_intlk
	task automatic t_local;
		@(posedge clock) sw.local_remote <= 1'b0;
		w(12); pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 0);
		@(posedge clock) sw.start_a <= 1'b1;
		w(12);
		@(posedge clock) sw.start_a <= 1'b0;
		w(12); chk(ca, 1);
		@(posedge clock) sw.stop_ok <= 1'b0;
		w(12); chk(ca, 0);
		@(posedge clock) sw.stop_ok <= 1'b1;
		@(posedge clock) sw.local_remote <= 1'b1;
		w(12);
	endtask : t_local
	task automatic t_test;
		pulse(0, 0, 0, 0, 1); watch(3); chk(h_run, 1);
		@(posedge clock) sw.test_pos <= 1'b1;
		w(12); chk(tpc, 1);
		pulse(0, 0, 0, 0, 1); watch(3); chk(h_run, 0);
		pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 1);
		@(posedge clock) sw.test_pos <= 1'b0;
		w(12); chk(ca, 0);
	endtask : t_test
	task automatic t_access;
		@(posedge clock) sw.access_short <= 1'b1;
		w(12); pulse(0, 0, 0, 1, 0); watch(3); chk(h_sp, 1);
		pulse(6'h04, 0, 0, 0, 0); w(1); chk(acc, 0);
		pulse(0, 0, 0, 1, 0); watch(3); chk(h_sp, 0);
		pulse(6'h01, 0, 0, 0, 0); watch(3); chk(h_sp, 1);
		pulse(6'h02, 0, 0, 0, 0); w(1); chk(acc, 1);
	endtask : t_access
	task automatic t_power;
		pulse(6'h20, 0, 0, 0, 0); w(12); chk(ca, 1);
		@(posedge clock) estop <= 1'b1;
		w(12); chk(ca, 0);
		@(posedge clock) estop <= 1'b0;
		w(12);
		pulse(6'h20, 0, 0, 0, 0); w(1); chk(ca, 1);
		pulse(0, 10'h049, 0, 0, 0); w(1); chk(ca, 0);
		@(posedge clock) pg <= 1'b0;
		@(posedge clock) pg <= 1'b1;
		w(2); chk(tl.ground_fault, 1);
		chk(tl.undercurrent, 0);
		chk(tl.thermal_lockout, 1);
		pulse(6'h08, 0, 0, 0, 0); w(1); chk(tl == '0, 1);
	endtask : t_power
	task results;
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// main sequence
	initial
	begin
		sw = '0;
		{sw.interlock, sw.stop_ok, sw.iso_no, sw.local_remote} = 4'hF;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		pg <= 1'b1;
		w(20);
		t_trip;
		t_intlk;
		t_local;
		t_test;
		t_access;
		t_power;
		results;
	end
endmodule : testbench
